// file: include/iefp_pkg.sv
// Package of register map, field positions, reset values and carrier types for the interrupt controller.
package iefp_pkg;
  // Register byte addresses on the APB.
  localparam logic [4:0] OFF_MAIN = 5'h00;
  localparam logic [4:0] OFF_EDGE = 5'h04;
  localparam logic [4:0] OFF_EXT = 5'h08;
  localparam logic [4:0] OFF_PFLAG = 5'h0C;
  localparam logic [4:0] OFF_RESET_CTRL = 5'h10;
  localparam logic [4:0] OFF_PEN = 5'h14;
  localparam logic [4:0] OFF_PPRI = 5'h18;
  localparam logic [4:0] OFF_STATUS = 5'h1C;
  // Values after reset.
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'hFF;
  localparam logic [7:0] RST_EXT = 8'hC0;
  localparam logic [7:0] RST_PFLAG = 8'h00;
  localparam logic [7:0] RST_RESET_CTRL = 8'h00;
  localparam logic [7:0] RST_PEN = 8'h00;
  localparam logic [7:0] RST_PPRI = 8'hFF;
  // Main control register fields.
  localparam int B_GLOBAL_HIGH = 7;
  localparam int B_PERIPH_LOW = 6;
  localparam int B_T0_EN = 5;
  localparam int B_X0_EN = 4;
  localparam int B_PC_EN = 3;
  localparam int B_T0_FLAG = 2;
  localparam int B_X0_FLAG = 1;
  localparam int B_PC_FLAG = 0;
  // Edge and priority register fields; edge select of pin n sits at B_X0_EDGE - n.
  localparam int B_PULLUP_DIS = 7;
  localparam int B_X0_EDGE = 6;
  localparam int B_T0_PRI = 2;
  localparam int B_X3_PRI = 1;
  localparam int B_PC_PRI = 0;
  // External pin register fields; pin n (1..3) flag at n-1, enable at n+2.
  localparam int B_X2_PRI = 7;
  localparam int B_X1_PRI = 6;
  localparam int B_X1_EN = 3;
  localparam int B_X1_FLAG = 0;
  // Peripheral flag register fields, then the priority feature bit of the reset control register.
  localparam int B_PSP = 7;
  localparam int B_ADC = 6;
  localparam int B_RX = 5;
  localparam int B_TX = 4;
  localparam int B_SSP = 3;
  localparam int B_CCP = 2;
  localparam int B_T2 = 1;
  localparam int B_T1 = 0;
  localparam int B_PRIO_FEATURE = 7;
  // Vector addresses handed to the core.
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW = 16'h0018;

  typedef enum logic [1:0] {
    IEFP_CCP_CAPTURE = 2'h0,
    IEFP_CCP_COMPARE = 2'h1,
    IEFP_CCP_PWM = 2'h3
  } iefp_ccp_mode_t;

  // Event inputs from the peripherals and pins, all synchronous to clk.
  typedef struct packed {
    logic timer_zero_overflow;
    logic [3:0] ext_pin;
    logic [3:0] port_b_input;
    logic port_b_read;
    logic converter_done;
    logic serial_one_rx_full;
    logic serial_one_tx_empty;
    logic sync_serial_one_done;
    logic capture_event;
    logic compare_event;
    iefp_ccp_mode_t ccp_mode;
    logic timer_two_match;
    logic timer_one_overflow;
    logic parallel_access;
    logic parallel_present;
  } iefp_events_t;
endpackage : iefp_pkg

// file: logic/iefp_ctrl.sv
// Interrupt enable, flag and priority controller with an APB register slave.
// Contract
// - Without priority, global enable gates all interrupts.
// - With priority, bit 7 enables high priority.
// - Without priority, peripheral enable gates peripheral interrupts.
// - With priority, bit 6 enables low priority.
// - Flags set regardless of any enable.
// - Timer zero overflow sets flag until cleared.
// - Upper port B change sets flag.
// - Persisting mismatch keeps flag set; read ends.
// - Edge select bits choose rising or falling.
// - Priority bits select high or low.
// - Pull-up disable bit kills all pull-ups.
// - Pins one to three flag on edge.
// - Pin zero flags on selected edge.
// - Receive flag mirrors buffer full, read-only.
// - Transmit flag mirrors buffer empty, read-only.
// - Conversion done sets converter flag.
// - Capture or compare per mode sets flag.
// - Timer two match, timer one overflow flag.
// - Sync serial completion sets its flag.
// - Parallel port access flag when present.
// - Priority feature bit, off after reset.
// - High vector 0008h, low 0018h.
// - Accepting interrupt clears applicable global enable.
module iefp_ctrl #(
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iefp_pkg::iefp_events_t events,
  input wire logic [7:0] port_b_latch,
  input wire logic core_ack,
  output logic core_irq,
  output logic [15:0] core_vector,
  output logic [7:0] port_b_pullup
);

  // The decoder compares five address bits; a narrower bus cannot reach every register.
  if (ADDR_W < 5) begin : g_bad_addr
    $error("ADDR_W must be at least 5.");
  end

  logic [7:0] main_reg, main_next;
  logic [7:0] edge_reg, edge_next;
  logic [7:0] ext_reg, ext_next;
  logic [7:0] pflag_reg, pflag_next;
  logic [7:0] rctl_reg, rctl_next;
  logic [7:0] pen_reg, pen_next;
  logic [7:0] ppri_reg, ppri_next;
  logic [3:0] pin_prev_reg;
  logic [3:0] last_read_reg;
  logic seeded_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic [15:0] vector_reg;
  logic [7:0] pullup_reg;
  logic [4:0] addr5;
  logic setup_ph, wr_en, hit;
  logic wr_main, wr_edge, wr_ext, wr_pflag, wr_rctl, wr_pen, wr_ppri;
  logic [3:0] pin_edge;
  logic mismatch, priority_feature_enable, ccp_hit;
  logic [5:0] core_flag, core_en, core_pri;
  logic [5:0] core_act;
  logic [7:0] per_act;
  logic any_core_hi, any_core_lo, any_per_hi, any_per_lo;
  logic req_hi, req_lo;

  assign addr5 = paddr[4:0];
  assign setup_ph = psel && !penable;
  // Writes land at the access edge, where pready is known to be high.
  assign wr_en = psel && penable && pwrite && pready_reg && pstrb[0];
  assign wr_main = wr_en && (addr5 == iefp_pkg::OFF_MAIN);
  assign wr_edge = wr_en && (addr5 == iefp_pkg::OFF_EDGE);
  assign wr_ext = wr_en && (addr5 == iefp_pkg::OFF_EXT);
  assign wr_pflag = wr_en && (addr5 == iefp_pkg::OFF_PFLAG);
  assign wr_rctl = wr_en && (addr5 == iefp_pkg::OFF_RESET_CTRL);
  assign wr_pen = wr_en && (addr5 == iefp_pkg::OFF_PEN);
  assign wr_ppri = wr_en && (addr5 == iefp_pkg::OFF_PPRI);
  assign priority_feature_enable = rctl_reg[iefp_pkg::B_PRIO_FEATURE];

  // Address decode for the error answer on pslverr; the read mux decodes addr5 itself.
  always_comb begin
    hit = 1'b1;
    if (addr5 == iefp_pkg::OFF_MAIN) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_EDGE) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_EXT) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_PFLAG) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_RESET_CTRL) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_PEN) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_PPRI) begin
      hit = 1'b1;
    end else if (addr5 == iefp_pkg::OFF_STATUS) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    if (ADDR_W > 5) begin
      if (paddr != ADDR_W'(addr5)) begin
        hit = 1'b0;
      end
    end
  end

  // Pin history for edge detection; the edge bit picks which transition counts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_reg <= 4'h0;
    end else begin
      pin_prev_reg <= events.ext_pin;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (edge_reg[iefp_pkg::B_X0_EDGE - i]) begin
        pin_edge[i] = events.ext_pin[i] && !pin_prev_reg[i];
      end else begin
        pin_edge[i] = !events.ext_pin[i] && pin_prev_reg[i];
      end
    end
  end

  // Last value read from the upper port pins; seeded after reset so idle pins are no mismatch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_read_reg <= 4'h0;
      seeded_reg <= 1'b0;
    end else begin
      seeded_reg <= 1'b1;
      if (events.port_b_read || !seeded_reg) begin
        last_read_reg <= events.port_b_input;
      end
    end
  end

  assign mismatch = seeded_reg && (events.port_b_input != last_read_reg);

  // Main control: software write, then acceptance clear, then hardware sets which win over any clear.
  always_comb begin
    main_next = main_reg;
    if (wr_main) begin
      main_next = pwdata[7:0];
    end
    if (core_ack) begin
      if (!priority_feature_enable || vector_reg == iefp_pkg::VEC_HIGH) begin
        main_next[iefp_pkg::B_GLOBAL_HIGH] = 1'b0;
      end else begin
        main_next[iefp_pkg::B_PERIPH_LOW] = 1'b0;
      end
    end
    if (events.timer_zero_overflow) begin
      main_next[iefp_pkg::B_T0_FLAG] = 1'b1;
    end
    if (pin_edge[0]) begin
      main_next[iefp_pkg::B_X0_FLAG] = 1'b1;
    end
    if (mismatch) begin
      main_next[iefp_pkg::B_PC_FLAG] = 1'b1;
    end
  end

  // External pins one to three: flags on selected edges.
  always_comb begin
    ext_next = ext_reg;
    if (wr_ext) begin
      ext_next = pwdata[7:0];
    end
    for (int i = 1; i < 4; i++) begin
      if (pin_edge[i]) begin
        ext_next[iefp_pkg::B_X1_FLAG + i - 1] = 1'b1;
      end
    end
  end

  // Peripheral flags; the serial bits follow the buffers and ignore writes.
  assign ccp_hit = (events.ccp_mode == iefp_pkg::IEFP_CCP_CAPTURE && events.capture_event) ||
                   (events.ccp_mode == iefp_pkg::IEFP_CCP_COMPARE && events.compare_event);

  always_comb begin
    pflag_next = pflag_reg;
    if (wr_pflag) begin
      pflag_next = pwdata[7:0];
    end
    pflag_next[iefp_pkg::B_RX] = events.serial_one_rx_full;
    pflag_next[iefp_pkg::B_TX] = events.serial_one_tx_empty;
    if (!events.parallel_present) begin
      pflag_next[iefp_pkg::B_PSP] = 1'b0;
    end else if (events.parallel_access) begin
      pflag_next[iefp_pkg::B_PSP] = 1'b1;
    end
    if (events.converter_done) begin
      pflag_next[iefp_pkg::B_ADC] = 1'b1;
    end
    if (events.sync_serial_one_done) begin
      pflag_next[iefp_pkg::B_SSP] = 1'b1;
    end
    if (ccp_hit) begin
      pflag_next[iefp_pkg::B_CCP] = 1'b1;
    end
    if (events.timer_two_match) begin
      pflag_next[iefp_pkg::B_T2] = 1'b1;
    end
    if (events.timer_one_overflow) begin
      pflag_next[iefp_pkg::B_T1] = 1'b1;
    end
  end

  // Plain configuration registers.
  always_comb begin
    edge_next = wr_edge ? pwdata[7:0] : edge_reg;
    rctl_next = wr_rctl ? (pwdata[7:0] & 8'h80) : rctl_reg;
    pen_next = wr_pen ? pwdata[7:0] : pen_reg;
    ppri_next = wr_ppri ? pwdata[7:0] : ppri_reg;
  end

  // Register state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_reg <= iefp_pkg::RST_MAIN;
      edge_reg <= iefp_pkg::RST_EDGE;
      ext_reg <= iefp_pkg::RST_EXT;
      pflag_reg <= iefp_pkg::RST_PFLAG;
      rctl_reg <= iefp_pkg::RST_RESET_CTRL;
      pen_reg <= iefp_pkg::RST_PEN;
      ppri_reg <= iefp_pkg::RST_PPRI;
    end else begin
      main_reg <= main_next;
      edge_reg <= edge_next;
      ext_reg <= ext_next;
      pflag_reg <= pflag_next;
      rctl_reg <= rctl_next;
      pen_reg <= pen_next;
      ppri_reg <= ppri_next;
    end
  end

  // Core sources in order: timer zero, pin zero, port change, pins one to three; pin zero is always high.
  assign core_flag = {ext_reg[2:0], main_reg[iefp_pkg::B_PC_FLAG], main_reg[iefp_pkg::B_X0_FLAG],
                      main_reg[iefp_pkg::B_T0_FLAG]};
  assign core_en = {ext_reg[5:3], main_reg[iefp_pkg::B_PC_EN], main_reg[iefp_pkg::B_X0_EN],
                    main_reg[iefp_pkg::B_T0_EN]};
  assign core_pri = {edge_reg[iefp_pkg::B_X3_PRI], ext_reg[iefp_pkg::B_X2_PRI], ext_reg[iefp_pkg::B_X1_PRI],
                     edge_reg[iefp_pkg::B_PC_PRI], 1'b1, edge_reg[iefp_pkg::B_T0_PRI]};
  assign core_act = core_flag & core_en;
  assign per_act = pflag_reg & pen_reg;
  assign any_core_hi = |(core_act & core_pri);
  assign any_core_lo = |(core_act & ~core_pri);
  assign any_per_hi = |(per_act & ppri_reg);
  assign any_per_lo = |(per_act & ~ppri_reg);

  // Request selection; with priority off the peripheral enable gates only peripheral sources.
  always_comb begin
    if (!priority_feature_enable) begin
      req_hi = main_reg[iefp_pkg::B_GLOBAL_HIGH] && ((|core_act) ||
               (main_reg[iefp_pkg::B_PERIPH_LOW] && (|per_act)));
      req_lo = 1'b0;
    end else begin
      req_hi = main_reg[iefp_pkg::B_GLOBAL_HIGH] && (any_core_hi || any_per_hi);
      // A cleared high enable blocks everything, so low requests need both enables.
      req_lo = main_reg[iefp_pkg::B_GLOBAL_HIGH] && main_reg[iefp_pkg::B_PERIPH_LOW] &&
               (any_core_lo || any_per_lo);
    end
  end

  // Request and vector to the core; a high request always overrides a low one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
      vector_reg <= iefp_pkg::VEC_HIGH;
    end else begin
      irq_reg <= req_hi || req_lo;
      vector_reg <= (req_hi || !req_lo) ? iefp_pkg::VEC_HIGH : iefp_pkg::VEC_LOW;
    end
  end

  // Pull-ups follow the port latch unless globally disabled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_reg <= 8'h00;
    end else begin
      pullup_reg <= edge_reg[iefp_pkg::B_PULLUP_DIS] ? 8'h00 : port_b_latch;
    end
  end

  // APB slave: the answer is prepared in the setup cycle so the access phase lasts one cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph && !hit;
      if (setup_ph && !pwrite) begin
        if (addr5 == iefp_pkg::OFF_MAIN) begin
          prdata_reg <= {24'h00_0000, main_reg};
        end else if (addr5 == iefp_pkg::OFF_EDGE) begin
          prdata_reg <= {24'h00_0000, edge_reg};
        end else if (addr5 == iefp_pkg::OFF_EXT) begin
          prdata_reg <= {24'h00_0000, ext_reg};
        end else if (addr5 == iefp_pkg::OFF_PFLAG) begin
          prdata_reg <= {24'h00_0000, pflag_reg};
        end else if (addr5 == iefp_pkg::OFF_RESET_CTRL) begin
          prdata_reg <= {24'h00_0000, rctl_reg};
        end else if (addr5 == iefp_pkg::OFF_PEN) begin
          prdata_reg <= {24'h00_0000, pen_reg};
        end else if (addr5 == iefp_pkg::OFF_PPRI) begin
          prdata_reg <= {24'h00_0000, ppri_reg};
        end else if (addr5 == iefp_pkg::OFF_STATUS) begin
          prdata_reg <= {vector_reg, 15'h0000, irq_reg};
        end else begin
          prdata_reg <= 32'h0000_0000;
        end
      end else if (!psel) begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign core_irq = irq_reg;
  assign core_vector = vector_reg;
  assign port_b_pullup = pullup_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Only a software write of zero may take the flag down in the cycle after it was set.
  a_timer_zero_flag: assert property (events.timer_zero_overflow |=> main_reg[iefp_pkg::B_T0_FLAG] ##1
    (main_reg[iefp_pkg::B_T0_FLAG] || ($past(wr_main) && !$past(pwdata[iefp_pkg::B_T0_FLAG]))))
    else $error("Timer zero flag not held after overflow.");
  a_pin_zero_rise: assert property (edge_reg[iefp_pkg::B_X0_EDGE] && !events.ext_pin[0] ##1
    events.ext_pin[0] && edge_reg[iefp_pkg::B_X0_EDGE] |=> main_reg[iefp_pkg::B_X0_FLAG])
    else $error("Pin zero rising edge did not set its flag.");
  a_port_mismatch: assert property (mismatch |=> main_reg[iefp_pkg::B_PC_FLAG])
    else $error("Port mismatch did not keep the change flag set.");
  a_global_blocks: assert property (!main_reg[iefp_pkg::B_GLOBAL_HIGH] |=> !core_irq)
    else $error("Request raised with global enable clear.");
  a_periph_blocks: assert property (!priority_feature_enable && !main_reg[iefp_pkg::B_PERIPH_LOW] && core_act == 6'h00
    |=> !core_irq)
    else $error("Peripheral request passed a clear peripheral enable.");
  a_low_vector: assert property (priority_feature_enable && req_lo && !req_hi |=> core_irq && core_vector == iefp_pkg::VEC_LOW)
    else $error("Low priority request not vectored low.");
  a_compat_vector: assert property (!priority_feature_enable && !$past(priority_feature_enable) && core_irq |-> core_vector == iefp_pkg::VEC_HIGH)
    else $error("Vector other than high with priority off.");
  a_ack_clears: assert property (core_ack && !priority_feature_enable && !wr_main |=> !main_reg[iefp_pkg::B_GLOBAL_HIGH])
    else $error("Accepted interrupt left the global enable set.");
  a_rx_mirror: assert property (##1 pflag_reg[iefp_pkg::B_RX] == $past(events.serial_one_rx_full))
    else $error("Receive flag does not follow the buffer.");
  a_pullup_off: assert property (edge_reg[iefp_pkg::B_PULLUP_DIS] |=> port_b_pullup == 8'h00)
    else $error("Pull-up active while disabled.");
  a_ready_next: assert property (setup_ph |=> pready ##1 !pready)
    else $error("Access phase not answered in one cycle.");

endmodule : iefp_ctrl

// file: verification/iefp_core_model.sv
// Behavioural processor core that acknowledges interrupt requests after a chosen delay.
module iefp_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ack_on,
  input wire logic [3:0] ack_wait,
  input wire logic core_irq,
  output logic core_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic busy;

  // One acknowledge per request; the core then waits for the request to drop, so a stale level is never taken twice.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      cnt <= 0;
      busy <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      if (busy) begin
        busy <= core_irq;
      end else if (ack_on && core_irq) begin
        if (cnt >= int'(ack_wait)) begin
          core_ack <= 1'b1;
          busy <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule : iefp_core_model

// file: verification/tb_interrupt_enable_flag_priority.sv
// Self-checking testbench of the interrupt controller against a behavioural register model.
module tb_interrupt_enable_flag_priority;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic core_ack, core_irq, ack_on = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [15:0] core_vector;
  logic [7:0] port_b_latch = 8'h00, port_b_pullup;
  logic [7:0] m [0:7];
  iefp_pkg::iefp_events_t ev = '0;
  iefp_pkg::iefp_events_t pm;
  integer seed = 32'hFEA09B93;
  int num_errors = 0;
  int comparisons = 0;

  // The clock inverts every half period of 25 ns.
  always #25 clk = ~clk;

  iefp_ctrl #(.ADDR_W(5)) iefp_ctrl_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(ev), .port_b_latch(port_b_latch), .core_ack(core_ack), .core_irq(core_irq),
    .core_vector(core_vector), .port_b_pullup(port_b_pullup));

  iefp_core_model iefp_core_model_inst (.clk(clk), .rst_n(rst_n), .ack_on(ack_on), .ack_wait(ack_wait),
    .core_irq(core_irq), .core_ack(core_ack));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // One APB transfer; the request is held until pready is sampled high, with a bounded wait.
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes keep the model in step; read-only mirror bits and the lone priority bit are masked.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    if (a == iefp_pkg::OFF_PFLAG) d = (d & 8'hCF) | (m[3] & 8'h30);
    if (a == iefp_pkg::OFF_RESET_CTRL) d = d & 8'h80;
    m[a[4:2]] = d;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    apb(1'b0, a, 32'h0);
    chk(r, {24'h0, m[a[4:2]]});
  endtask : rd

  task automatic pulse(input iefp_pkg::iefp_events_t p);
    @(posedge clk);
    ev <= iefp_pkg::iefp_events_t'(ev | p);
    @(posedge clk);
    ev <= iefp_pkg::iefp_events_t'(ev & ~p);
    repeat (2) @(posedge clk);
  endtask : pulse

  // Expected request and vector from the model, as {irq, vector}.
  function automatic logic [16:0] want();
    logic [7:0] mm, x, f;
    logic [5:0] src, hp;
    logic hs, ls;
    mm = m[0];
    x = m[2];
    f = m[3] & m[5];
    src = {mm[2] & mm[5], mm[1] & mm[4], mm[0] & mm[3], x[0] & x[3], x[1] & x[4], x[2] & x[5]};
    hp = {m[1][2], 1'b1, m[1][0], x[6], x[7], m[1][1]};
    if (!m[4][7]) begin
      hs = mm[7] & (|src | (mm[6] & |f));
      return {hs, hs ? 16'h0008 : 16'h0000};
    end
    hs = mm[7] & (|(src & hp) | |(f & m[6]));
    ls = mm[7] & mm[6] & (|(src & ~hp) | |(f & ~m[6]));
    return {hs | ls, hs ? 16'h0008 : (ls ? 16'h0018 : 16'h0000)};
  endfunction : want

  // Main sequence: reset values, event flags, edges, port change, random gating, then acknowledges.
  initial begin
    int k;
    ev.parallel_present <= 1'b1;
    m = '{8'h00, 8'hFF, 8'hC0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(5'(i * 4));
    apb(1'b0, 5'h02, 32'h0);
    chk(perr, 32'h1);
    pm = '0;
    pm.timer_zero_overflow = 1'b1;
    pm.converter_done = 1'b1;
    pm.sync_serial_one_done = 1'b1;
    pm.timer_two_match = 1'b1;
    pm.timer_one_overflow = 1'b1;
    pm.parallel_access = 1'b1;
    pm.capture_event = 1'b1;
    pulse(pm);
    m[0] = 8'h04;
    m[3] = 8'hCF;
    rd(iefp_pkg::OFF_MAIN);
    rd(iefp_pkg::OFF_PFLAG);
    chk(core_irq, 32'h0);
    wr(iefp_pkg::OFF_MAIN, 8'h00);
    rd(iefp_pkg::OFF_MAIN);
    // Capture and compare events in each mode; only the matching pair may set the flag.
    for (int c = 0; c < 6; c++) begin
      ev.ccp_mode <= iefp_pkg::iefp_ccp_mode_t'(2'(c / 2 == 2 ? 3 : c / 2));
      wr(iefp_pkg::OFF_PFLAG, 8'h00);
      pm = '0;
      pm.capture_event = (c % 2 == 0);
      pm.compare_event = (c % 2 == 1);
      pulse(pm);
      if (c == 0 || c == 3) m[3] = 8'h04;
      rd(iefp_pkg::OFF_PFLAG);
    end
    ev.parallel_present <= 1'b0;
    wr(iefp_pkg::OFF_PFLAG, 8'h00);
    pm = '0;
    pm.parallel_access = 1'b1;
    pulse(pm);
    rd(iefp_pkg::OFF_PFLAG);
    ev.parallel_present <= 1'b1;
    ev.serial_one_rx_full <= 1'b1;
    repeat (2) @(posedge clk);
    m[3] = 8'h20;
    wr(iefp_pkg::OFF_PFLAG, 8'h00);
    rd(iefp_pkg::OFF_PFLAG);
    ev.serial_one_rx_full <= 1'b0;
    ev.serial_one_tx_empty <= 1'b1;
    repeat (2) @(posedge clk);
    m[3] = 8'h10;
    rd(iefp_pkg::OFF_PFLAG);
    ev.serial_one_tx_empty <= 1'b0;
    repeat (2) @(posedge clk);
    m[3] = 8'h00;
    // Every pin with both edge selects: the chosen edge sets the flag, the opposite edge does not.
    for (int n = 0; n < 4; n++) begin
      for (int s = 0; s < 2; s++) begin
        wr(iefp_pkg::OFF_EDGE, s ? 8'hFF : 8'hFF ^ (8'h40 >> n));
        ev.ext_pin[n] <= !s;
        repeat (3) @(posedge clk);
        wr(iefp_pkg::OFF_MAIN, 8'h00);
        wr(iefp_pkg::OFF_EXT, 8'hC0);
        ev.ext_pin[n] <= s[0];
        repeat (3) @(posedge clk);
        if (n == 0) m[0][1] = 1'b1;
        else m[2][n - 1] = 1'b1;
        rd(iefp_pkg::OFF_MAIN);
        rd(iefp_pkg::OFF_EXT);
        wr(iefp_pkg::OFF_MAIN, 8'h00);
        wr(iefp_pkg::OFF_EXT, 8'hC0);
        ev.ext_pin[n] <= !s;
        repeat (3) @(posedge clk);
        rd(iefp_pkg::OFF_MAIN);
        rd(iefp_pkg::OFF_EXT);
      end
    end
    ev.port_b_input <= 4'($random(seed)) | 4'h1;
    repeat (3) @(posedge clk);
    m[0] = 8'h01;
    rd(iefp_pkg::OFF_MAIN);
    wr(iefp_pkg::OFF_MAIN, 8'h00);
    m[0] = 8'h01;
    rd(iefp_pkg::OFF_MAIN);
    pm = '0;
    pm.port_b_read = 1'b1;
    pulse(pm);
    wr(iefp_pkg::OFF_MAIN, 8'h00);
    rd(iefp_pkg::OFF_MAIN);
    // Random register contents over 60 rounds exercise gating, priority and pull-up combinations.
    for (int i = 0; i < 60; i++) begin
      port_b_latch <= 8'($random(seed));
      for (int a = 0; a < 7; a++) wr(5'(a * 4), 8'($random(seed)));
      repeat (3) @(posedge clk);
      chk({core_irq, core_irq ? core_vector : 16'h0000}, want());
      chk(port_b_pullup, m[1][7] ? 8'h00 : port_b_latch);
    end
    // Acknowledge without and with priority; a prompt and a slow core.
    for (int pe = 0; pe < 2; pe++) begin
      wr(iefp_pkg::OFF_RESET_CTRL, pe ? 8'h80 : 8'h00);
      wr(iefp_pkg::OFF_EDGE, 8'hFB);
      wr(iefp_pkg::OFF_EXT, 8'hC0);
      wr(iefp_pkg::OFF_PEN, 8'h00);
      wr(iefp_pkg::OFF_PFLAG, 8'h00);
      wr(iefp_pkg::OFF_MAIN, 8'hE4);
      repeat (3) @(posedge clk);
      chk(core_vector, pe ? 16'h0018 : 16'h0008);
      apb(1'b0, iefp_pkg::OFF_STATUS, 32'h0);
      chk(r, {pe ? 16'h0018 : 16'h0008, 15'h0000, 1'b1});
      ack_wait <= pe ? 4'h5 : 4'h0;
      ack_on <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (core_ack !== 1'b1 && k < 40);
      if (k >= 40) begin
        num_errors++;
        final_report();
      end
      ack_on <= 1'b0;
      m[0] = pe ? 8'hA4 : 8'h64;
      repeat (3) @(posedge clk);
      rd(iefp_pkg::OFF_MAIN);
      chk(core_irq, 32'h0);
    end
    final_report();
  end
endmodule : tb_interrupt_enable_flag_priority
